// [control_transfer_unit.sv]
// Strobed register access and the register addresses were decided locally.
`include "ctu_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module control_transfer_unit
    import ctu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        op_valid,
    input  wire ctu_op_e     op_code,
    input  wire cond_e       op_cond,
    input  wire logic [31:0] next_ip,
    input  wire logic [31:0] disp,
    input  wire logic [31:0] target_off,
    input  wire logic [15:0] target_sel,
    input  wire logic [15:0] ret_imm,
    input  wire logic        addr16,
    input  wire logic        prot_mode,
    input  wire logic [31:0] stk_rdata,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    output logic             busy,
    output logic             done,
    output logic             taken,
    output logic             gate_req,
    output logic [31:0]      instr_pointer,
    output logic [15:0]      code_seg,
    output logic [31:0]      stack_pointer,
    output logic [31:0]      flags_register,
    output logic             stk_wr,
    output logic             stk_rd,
    output logic [31:0]      stk_addr,
    output logic [31:0]      stk_wdata
);
    ////////////////////////////////////////////////////////////////////
    // condition decode
    logic [31:0] count_q;
    logic        carry_flag, zero_flag, overflow_flag, parity_flag, sign_flag;
    logic        cond_true;
    assign carry_flag    = flags_register[`CTU_CF_BIT];
    assign zero_flag     = flags_register[`CTU_ZF_BIT];
    assign overflow_flag = flags_register[`CTU_OF_BIT];
    assign parity_flag   = flags_register[`CTU_PF_BIT];
    assign sign_flag     = flags_register[`CTU_SF_BIT];

    always_comb begin
        cond_true = 1'b0;
        unique case (op_cond)
            CC_OVERFLOW:      cond_true = overflow_flag;
            CC_NO_OVERFLOW:   cond_true = !overflow_flag;
            CC_BELOW:         cond_true = carry_flag;
            CC_ABOVE_EQUAL:   cond_true = !carry_flag;
            CC_ZERO:          cond_true = zero_flag;
            CC_NOT_ZERO:      cond_true = !zero_flag;
            CC_BELOW_EQUAL:   cond_true = carry_flag | zero_flag;
            CC_ABOVE:         cond_true = !(carry_flag | zero_flag);
            CC_SIGN:          cond_true = sign_flag;
            CC_NO_SIGN:       cond_true = !sign_flag;
            CC_PARITY:        cond_true = parity_flag;
            CC_NO_PARITY:     cond_true = !parity_flag;
            CC_LESS:          cond_true = sign_flag ^ overflow_flag;
            CC_GREATER_EQUAL: cond_true = !(sign_flag ^ overflow_flag);
            CC_LESS_EQUAL:    cond_true = (sign_flag ^ overflow_flag) | zero_flag;
            CC_GREATER:       cond_true = !((sign_flag ^ overflow_flag) | zero_flag);
            CC_COUNT_ZERO:    cond_true = addr16 ? (count_q[15:0] == 16'h0000)
                                                 : (count_q == 32'h0000_0000);
            default:          cond_true = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // target resolution
    logic [31:0] rel_target;
    logic        is_call, is_far;
    assign rel_target = next_ip + disp;
    assign is_call = (op_code == OP_CALL_REL) || (op_code == OP_CALL_REG)
                   || (op_code == OP_CALL_NEAR_MEM) || (op_code == OP_CALL_FAR_MEM);
    assign is_far  = (op_code == OP_JUMP_FAR_MEM) || (op_code == OP_CALL_FAR_MEM);

    ////////////////////////////////////////////////////////////////////
    // sequencer
    seq_e        state_q;
    logic [31:0] tgt_ip_q;
    logic [15:0] tgt_cs_q;
    logic        far_q;
    logic        intr_return_q;
    logic [15:0] imm_q;
    logic        start;
    assign start = op_valid && !busy;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            tgt_ip_q <= `CTU_IP_RST;
            tgt_cs_q <= `CTU_CS_RST;
            far_q    <= 1'b0;
            intr_return_q   <= 1'b0;
            imm_q    <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: if (start) begin
                    tgt_ip_q <= (op_code == OP_CALL_REL) ? rel_target : target_off;
                    tgt_cs_q <= target_sel;
                    far_q    <= is_far;
                    intr_return_q   <= (op_code == OP_INTR_RETURN);
                    imm_q    <= ret_imm;
                    if (is_call) state_q <= is_far ? ST_PUSH_CS : ST_PUSH_IP;
                    else if (op_code == OP_INTR_ENTER) state_q <= ST_PUSH_FLAGS;
                    else if (op_code == OP_RETURN || op_code == OP_INTR_RETURN) state_q <= ST_POP_IP;
                end
                ST_PUSH_FLAGS: state_q <= ST_PUSH_CS;
                ST_PUSH_CS:    state_q <= ST_PUSH_IP;
                ST_PUSH_IP:    state_q <= ST_DONE;
                ST_POP_IP:     state_q <= (intr_return_q || far_q) ? ST_POP_CS : ST_DONE;
                ST_POP_CS:     state_q <= intr_return_q ? ST_POP_FLAGS : ST_DONE;
                ST_POP_FLAGS:  state_q <= ST_DONE;
                ST_DONE:       state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stack port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stk_wr    <= 1'b0;
            stk_rd    <= 1'b0;
            stk_addr  <= `CTU_SP_RST;
            stk_wdata <= 32'h0000_0000;
        end else begin
            stk_wr <= 1'b0;
            stk_rd <= 1'b0;
            unique case (state_q)
                ST_PUSH_FLAGS: begin
                    stk_wr    <= 1'b1;
                    stk_addr  <= stack_pointer - `CTU_WORD_BYTES;
                    stk_wdata <= flags_register;
                end
                ST_PUSH_CS: begin
                    stk_wr    <= 1'b1;
                    stk_addr  <= stack_pointer - `CTU_WORD_BYTES;
                    stk_wdata <= {16'h0000, code_seg};
                end
                ST_PUSH_IP: begin
                    stk_wr    <= 1'b1;
                    stk_addr  <= stack_pointer - `CTU_WORD_BYTES;
                    stk_wdata <= instr_pointer;
                end
                ST_POP_IP, ST_POP_CS, ST_POP_FLAGS: begin
                    stk_rd   <= 1'b1;
                    stk_addr <= stack_pointer;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // architectural state
    seq_e pop_kind_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) pop_kind_q <= ST_IDLE;
        else        pop_kind_q <= (state_q == ST_POP_IP || state_q == ST_POP_CS
                                   || state_q == ST_POP_FLAGS) ? state_q : ST_IDLE;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_pointer  <= `CTU_IP_RST;
            code_seg       <= `CTU_CS_RST;
            stack_pointer  <= `CTU_SP_RST;
            flags_register <= `CTU_FLAGS_RST;
            count_q        <= 32'h0000_0000;
            taken          <= 1'b0;
            gate_req       <= 1'b0;
        end else begin
            gate_req <= 1'b0;
            if (start) begin
                taken         <= 1'b1;
                instr_pointer <= next_ip;
                unique case (op_code)
                    OP_JUMP_REL:      instr_pointer <= rel_target;
                    OP_JUMP_REG,
                    OP_JUMP_NEAR_MEM: instr_pointer <= target_off;
                    OP_JUMP_FAR_MEM: begin
                        instr_pointer <= target_off;
                        code_seg      <= target_sel;
                    end
                    OP_JUMP_GATE: begin
                        gate_req <= prot_mode;
                        taken    <= prot_mode;
                    end
                    OP_JCC: begin
                        taken <= cond_true;
                        if (cond_true) instr_pointer <= rel_target;
                    end
                    default: ;
                endcase
            end
            if (state_q == ST_PUSH_FLAGS || state_q == ST_PUSH_CS || state_q == ST_PUSH_IP)
                stack_pointer <= stack_pointer - `CTU_WORD_BYTES;
            if (state_q == ST_PUSH_IP) begin
                instr_pointer <= tgt_ip_q;
                if (far_q) code_seg <= tgt_cs_q;
            end
            if (state_q == ST_POP_IP || state_q == ST_POP_CS || state_q == ST_POP_FLAGS)
                stack_pointer <= stack_pointer + `CTU_WORD_BYTES;
            if (state_q == ST_DONE && pop_kind_q == ST_IDLE && imm_q != 16'h0000 && !intr_return_q)
                stack_pointer <= stack_pointer;
            unique case (pop_kind_q)
                ST_POP_IP: begin
                    instr_pointer <= stk_rdata;
                    if (!(intr_return_q || far_q)) stack_pointer <= stack_pointer + {16'h0000, imm_q};
                end
                ST_POP_CS: begin
                    code_seg <= stk_rdata[15:0];
                    if (!intr_return_q) stack_pointer <= stack_pointer + {16'h0000, imm_q};
                end
                ST_POP_FLAGS: flags_register <= stk_rdata;
                default: ;
            endcase
            if (reg_wr) begin
                unique case (reg_addr)
                    `CTU_ADDR_IP:    instr_pointer  <= reg_wdata;
                    `CTU_ADDR_SP:    stack_pointer  <= reg_wdata;
                    `CTU_ADDR_FLAGS: flags_register <= reg_wdata;
                    `CTU_ADDR_CS:    code_seg       <= reg_wdata[15:0];
                    `CTU_ADDR_COUNT: count_q        <= reg_wdata;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status and read port
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            busy <= (state_q != ST_IDLE && state_q != ST_DONE) || (start && (is_call
                    || op_code == OP_INTR_ENTER || op_code == OP_RETURN || op_code == OP_INTR_RETURN));
            done <= (start && !(is_call || op_code == OP_INTR_ENTER || op_code == OP_RETURN
                    || op_code == OP_INTR_RETURN || op_code == OP_NONE)) || (state_q == ST_DONE);
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    `CTU_ADDR_IP:     reg_rdata <= instr_pointer;
                    `CTU_ADDR_SP:     reg_rdata <= stack_pointer;
                    `CTU_ADDR_FLAGS:  reg_rdata <= flags_register;
                    `CTU_ADDR_CS:     reg_rdata <= {16'h0000, code_seg};
                    `CTU_ADDR_COUNT:  reg_rdata <= count_q;
                    `CTU_ADDR_STATUS: reg_rdata <= {29'h0, taken, busy, cond_true};
                    default:          reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    jump_rel_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_JUMP_REL && !reg_wr |=> instr_pointer == $past(next_ip + disp))
        else $error("relative jump target wrong");
    jump_no_push_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_JCC |=> !stk_wr [*3])
        else $error("conditional jump wrote stack");
    jcc_false_seq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_JCC && !cond_true && !reg_wr |=> instr_pointer == $past(next_ip) && !taken)
        else $error("false condition did not fall through");
    call_push_ret_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_CALL_REL && !reg_wr |=> ##1 stk_wr && stk_wdata == $past(next_ip, 2))
        else $error("call pushed wrong return address");
    intr_push_flags_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_INTR_ENTER |=> ##1 stk_wr && stk_wdata == $past(flags_register, 2))
        else $error("flags not pushed on interrupt");
    ret_pop_ip_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && op_code == OP_RETURN |=> ##1 stk_rd ##1 (instr_pointer == $past(stk_rdata)) || $past(reg_wr))
        else $error("return did not load popped address");
    count_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_cond == CC_COUNT_ZERO && !addr16 && count_q == 32'h0000_0000 |-> cond_true)
        else $error("count zero not taken");
    greater_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_cond == CC_GREATER |-> cond_true == (sign_flag == overflow_flag && !zero_flag))
        else $error("signed greater decode wrong");
    above_dec_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        op_cond == CC_ABOVE |-> cond_true == (!carry_flag && !zero_flag))
        else $error("unsigned above decode wrong");
endmodule : control_transfer_unit
`default_nettype wire

// [ctu_cfg.svh]
`ifndef CTU_CFG_SVH
`define CTU_CFG_SVH
`define CTU_IP_RST       32'h0000_0000
`define CTU_SP_RST       32'h0000_0000
`define CTU_CS_RST       16'h0000
`define CTU_FLAGS_RST    32'h0000_0002
`define CTU_CF_BIT       0
`define CTU_PF_BIT       2
`define CTU_ZF_BIT       6
`define CTU_SF_BIT       7
`define CTU_OF_BIT       11
`define CTU_WORD_BYTES   32'h0000_0004
`define CTU_ADDR_CTRL    4'h0
`define CTU_ADDR_IP      4'h1
`define CTU_ADDR_SP      4'h2
`define CTU_ADDR_FLAGS   4'h3
`define CTU_ADDR_CS      4'h4
`define CTU_ADDR_COUNT   4'h5
`define CTU_ADDR_STATUS  4'h6
`endif

// [ctu_pkg.sv]
package ctu_pkg;
    typedef enum logic [4:0] {
        OP_NONE, OP_JUMP_REL, OP_JUMP_REG, OP_JUMP_NEAR_MEM, OP_JUMP_FAR_MEM, OP_JUMP_GATE,
        OP_CALL_REL, OP_CALL_REG, OP_CALL_NEAR_MEM, OP_CALL_FAR_MEM,
        OP_RETURN, OP_INTR_ENTER, OP_INTR_RETURN, OP_JCC
    } ctu_op_e;
    typedef enum logic [4:0] {
        CC_OVERFLOW, CC_NO_OVERFLOW, CC_BELOW, CC_ABOVE_EQUAL, CC_ZERO, CC_NOT_ZERO,
        CC_BELOW_EQUAL, CC_ABOVE, CC_SIGN, CC_NO_SIGN, CC_PARITY, CC_NO_PARITY,
        CC_LESS, CC_GREATER_EQUAL, CC_LESS_EQUAL, CC_GREATER, CC_COUNT_ZERO
    } cond_e;
    typedef enum logic [2:0] {
        ST_IDLE, ST_PUSH_FLAGS, ST_PUSH_CS, ST_PUSH_IP, ST_POP_IP, ST_POP_CS, ST_POP_FLAGS, ST_DONE
    } seq_e;
endpackage : ctu_pkg

// [stack_model.sv]
`timescale 1ns/1ps
`default_nettype none
module stack_model (
    input  wire logic        core_clk,
    input  wire logic        stk_wr,
    input  wire logic        stk_rd,
    input  wire logic [31:0] stk_addr,
    input  wire logic [31:0] stk_wdata,
    output logic [31:0]      stk_rdata
);
    logic [31:0] mem [0:511];
    logic [31:0] word_q = 32'hA5A5_0000;
    ////////////////////////////////////////////////////////////////
    // word store, grows down, four bytes a word
    always_ff @(posedge core_clk) begin
        if (stk_wr) begin
            mem[stk_addr[10:2]] <= stk_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////
    // read word valid in the strobe cycle, sampled at its closing edge
    always @(posedge core_clk) begin
        word_q <= word_q + 32'h9E37_79B9;
    end
    // outside that cycle a changing pattern, never the last word
    assign stk_rdata = stk_rd ? mem[stk_addr[10:2]] : ~word_q;
endmodule : stack_model
`default_nettype wire

// [tb_top.sv]
`include "ctu_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ctu_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, addr16 = 1'b0, prot_mode = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, busy, done, taken, gate_req, stk_wr, stk_rd;
    ctu_op_e op_code = OP_NONE;
    cond_e op_cond = CC_OVERFLOW;
    logic [31:0] next_ip = '0, disp = '0, target_off = '0, reg_wdata = '0, stk_rdata, reg_rdata;
    logic [31:0] instr_pointer, stack_pointer, flags_register, stk_addr, stk_wdata;
    logic [15:0] target_sel = '0, ret_imm = '0, code_seg;
    logic [3:0]  reg_addr = '0;
    int          n_mismatch = 0, total_checks = 0, n_push = 0, n_gate = 0;
    always #12.5 core_clk = ~core_clk;
    control_transfer_unit uut (.core_clk, .rst_n, .op_valid, .op_code, .op_cond, .next_ip, .disp,
        .target_off, .target_sel, .ret_imm, .addr16, .prot_mode, .stk_rdata, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .busy, .done, .taken, .gate_req, .instr_pointer, .code_seg,
        .stack_pointer, .flags_register, .stk_wr, .stk_rd, .stk_addr, .stk_wdata);
    stack_model stack (.core_clk, .stk_wr, .stk_rd, .stk_addr, .stk_wdata, .stk_rdata);
    always @(posedge core_clk) begin
        if (stk_wr === 1'b1) n_push++;
        if (gate_req === 1'b1) n_gate++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rreg
    task automatic run_op(input ctu_op_e op, input cond_e c, input logic [31:0] n, d, t,
                          input logic [15:0] s, imm);
        int i;
        @(posedge core_clk);
        op_code    <= op;
        op_cond    <= c;
        next_ip    <= n;
        disp       <= d;
        target_off <= t;
        target_sel <= s;
        ret_imm    <= imm;
        op_valid <= 1'b1;
        @(posedge core_clk);
        op_valid <= 1'b0;
        #1 i = 0;
        while ((done !== 1'b1 || busy !== 1'b0) && i < 30) begin
            @(posedge core_clk);
            #1 i++;
        end
        if (i == 30) begin
            n_mismatch++;
            $display("BAD done expected 1 seen timeout");
            conclude();
        end
    endtask : run_op
    function automatic logic cond_ok(input cond_e c, input logic [31:0] f, cnt, input logic a16);
        logic cf, pf, zf, sf, of;
        {cf, pf, zf, sf, of} = {f[`CTU_CF_BIT], f[`CTU_PF_BIT], f[`CTU_ZF_BIT], f[`CTU_SF_BIT], f[`CTU_OF_BIT]};
        case (c)
            CC_OVERFLOW:      return of;
            CC_NO_OVERFLOW:   return !of;
            CC_BELOW:         return cf;
            CC_ABOVE_EQUAL:   return !cf;
            CC_ZERO:          return zf;
            CC_NOT_ZERO:      return !zf;
            CC_BELOW_EQUAL:   return cf | zf;
            CC_ABOVE:         return !(cf | zf);
            CC_SIGN:          return sf;
            CC_NO_SIGN:       return !sf;
            CC_PARITY:        return pf;
            CC_NO_PARITY:     return !pf;
            CC_LESS:          return sf ^ of;
            CC_GREATER_EQUAL: return !(sf ^ of);
            CC_LESS_EQUAL:    return (sf ^ of) | zf;
            CC_GREATER:       return !((sf ^ of) | zf);
            default:          return a16 ? (cnt[15:0] == 16'h0000) : (cnt == 32'h0000_0000);
        endcase
    endfunction : cond_ok
    function automatic logic [31:0] memw(input logic [31:0] a);
        return stack.mem[a[10:2]];
    endfunction : memw
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] n, d, t, sp0, f, cnt, rd;
        logic [15:0] s, cs0, imm;
        int          p0, g0;
        ctu_op_e     ops [4] = '{OP_CALL_REL, OP_CALL_REG, OP_CALL_NEAR_MEM, OP_CALL_FAR_MEM};
        void'($urandom(89));
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        chk("flags reset", 32'h0000_0002, flags_register);
        rreg(4'hF, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        wreg(`CTU_ADDR_SP, 32'h0000_0400);
        rreg(`CTU_ADDR_SP, rd);
        chk("sp readback", 32'h0000_0400, rd);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            {n, t, s} = {$urandom, $urandom, 16'($urandom)};
            d = (k == 0) ? 32'hFFFF_FFF0 : $urandom;
            {p0, cs0} = {n_push, code_seg};
            run_op(OP_JUMP_REL, CC_OVERFLOW, n, d, t, s, 16'h0);
            chk("ip rel", n + d, instr_pointer);
            chk("taken rel", 32'(1'b1), 32'(taken));
            run_op(OP_JUMP_REG, CC_OVERFLOW, n, d, t, s, 16'h0);
            chk("ip reg", t, instr_pointer);
            chk("cs reg", 32'(cs0), 32'(code_seg));
            run_op(OP_JUMP_NEAR_MEM, CC_OVERFLOW, n, d, t + 32'h4, s, 16'h0);
            chk("ip near", t + 32'h4, instr_pointer);
            chk("cs near", 32'(cs0), 32'(code_seg));
            run_op(OP_JUMP_FAR_MEM, CC_OVERFLOW, n, d, t, s, 16'h0);
            chk("ip far", t, instr_pointer);
            chk("cs far", 32'(s), 32'(code_seg));
            chk("no push", p0, n_push);
        end
        g0 = n_gate;
        run_op(OP_JUMP_GATE, CC_OVERFLOW, n, d, t, s, 16'h0);
        chk("gate real mode", 32'(1'b0), 32'(taken));
        chk("gate refused", 32'(1'b0), 32'(gate_req));
        prot_mode <= 1'b1;
        run_op(OP_JUMP_GATE, CC_OVERFLOW, n, d, t, s, 16'h0);
        chk("gate handed", 32'(1'b1), 32'(gate_req));
        prot_mode <= 1'b0;
        $display("test jumps done");
        for (int k = 0; k < 8; k++) begin
            {n, d, t, s} = {$urandom, $urandom, $urandom, 16'($urandom)};
            imm = (k == 0) ? 16'h0000 : 16'(($urandom % 8) * 4);
            wreg(`CTU_ADDR_SP, 32'h0000_0400);
            {sp0, cs0} = {32'h0000_0400, code_seg};
            run_op(ops[k % 4], CC_OVERFLOW, n, d, t, s, 16'h0);
            chk("call ip", (ops[k % 4] == OP_CALL_REL) ? n + d : t, instr_pointer);
            chk("call cs", 32'((k % 4 == 3) ? s : cs0), 32'(code_seg));
            chk("call sp", sp0 - ((k % 4 == 3) ? 32'h8 : 32'h4), stack_pointer);
            chk("pushed ip", n, memw(stack_pointer));
            if (k % 4 == 3) chk("pushed cs", 32'(cs0), 32'(memw(sp0 - 32'h4) & 32'h0000_FFFF));
            else begin
                run_op(OP_RETURN, CC_OVERFLOW, 32'h0, d, t, s, imm);
                chk("ret ip", n, instr_pointer);
                chk("ret sp", sp0 + 32'(imm), stack_pointer);
            end
        end
        wreg(`CTU_ADDR_SP, 32'h0000_0400);
        f = 32'h2 | ($urandom & 32'h0000_08C5);
        wreg(`CTU_ADDR_FLAGS, f);
        {n, sp0, cs0} = {$urandom, stack_pointer, code_seg};
        run_op(OP_INTR_ENTER, CC_OVERFLOW, n, d, t, s, 16'h0);
        chk("intr sp", sp0 - 32'hC, stack_pointer);
        chk("pushed flags", f, memw(sp0 - 32'h4));
        chk("pushed rip", n, memw(sp0 - 32'hC));
        wreg(`CTU_ADDR_FLAGS, f ^ 32'h0000_08C5);
        run_op(OP_INTR_RETURN, CC_OVERFLOW, 32'h0, d, t, s, 16'h0);
        chk("intr_return ip", n, instr_pointer);
        chk("intr_return flags", f, flags_register);
        chk("intr_return cs", 32'(cs0), 32'(code_seg));
        chk("intr_return sp", sp0, stack_pointer);
        chk("gate count", g0 + 1, n_gate);
        $display("test calls done");
        for (int c = 0; c < 17; c++) begin
            for (int r = 0; r < 4; r++) begin
                {n, d, f} = {$urandom, $urandom, 32'h2 | ($urandom & 32'h0000_08C5)};
                cnt = (r == 0) ? 32'h0 : (r == 1) ? 32'hFFFF_0000 : $urandom % 3;
                wreg(`CTU_ADDR_FLAGS, f);
                wreg(`CTU_ADDR_COUNT, cnt);
                addr16 <= 1'($urandom);
                p0 = n_push;
                run_op(OP_JCC, cond_e'(c), n, d, t, s, 16'h0);
                chk("cond taken", 32'(cond_ok(cond_e'(c), f, cnt, addr16)), 32'(taken));
                chk("cond ip", cond_ok(cond_e'(c), f, cnt, addr16) ? n + d : n, instr_pointer);
                chk("cond no push", p0, n_push);
            end
        end
        $display("test conditions done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
